// ===== logic/conv_timer.sv
// Conversion cycle counter: sampling phase, then ten equal bit steps
module conv_timer
	import sar_adc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sequencing
	conv_if.timer cv
);

	timer_regs_type state_reg;
	timer_regs_type state_next;
	logic [10:0] ten_steps;

	assign ten_steps = 11'(cv.step) * 11'h00a;
	assign cv.sampling = state_reg.run && (state_reg.rem >= ten_steps);
	assign cv.step_end = state_reg.run && !cv.sampling
		&& (state_reg.scnt == 7'h00);

	always_comb begin
		state_next = state_reg;
		if (cv.start) begin
			// Two clocks are spent outside the counter: load and result commit
			state_next.run = 1'b1;
			state_next.rem = cv.total - 11'h002;
			state_next.scnt = cv.step - 7'h01;
		end else if (cv.abort) begin
			state_next.run = 1'b0;
		end else if (state_reg.run) begin
			if (state_reg.rem == 11'h000) begin
				state_next.run = 1'b0;
			end else begin
				state_next.rem = state_reg.rem - 11'h001;
			end
			if (!cv.sampling) begin
				if (state_reg.scnt == 7'h00) begin
					state_next.scnt = cv.step - 7'h01;
				end else begin
					state_next.scnt = state_reg.scnt - 7'h01;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule

// ===== logic/sar_adc_control.sv
// Converter control: register file, sequencing, result and status
//
// Decided for this implementation: the APB interface to the registers.
`include "sar_adc_defs.svh"

module sar_adc_control
	import sar_adc_pkg::*;
#(
	parameter int ADDR_WIDTH = 12,
	parameter int RESULT_BITS = 10
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Standby requests from the power manager, same clock
	input wire logic stop_mode,
	input wire logic slow_mode,
	input wire logic sleep_mode,
	// Analog front end
	input wire logic comp_above,
	output logic [9:0] dac_code,
	output logic sample_hold,
	output logic ladder_connect,
	output logic analog_input_gate,
	output logic [5:0] channel_enable,
	// Completion event
	output logic conversion_done_irq
);

	// ==========================================================
	// Parameter checks
	if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr
		$error("ADDR_WIDTH must lie between 8 and 32");
	end
	if (RESULT_BITS != 10) begin : g_bad_bits
		$error("RESULT_BITS must be 10");
	end
	if (`CHANNEL_COUNT != 6) begin : g_bad_route
		$error("Channel count must match the six input enables");
	end

	// ==========================================================
	// Declarations
	ctrl_regs_type state_reg;
	ctrl_regs_type state_next;
	conv_if cv();
	logic [9:0] index;
	logic [5:0] route_sel;
	logic standby;
	logic wr_done;
	logic rd_done;
	logic [10:0] total_sel;
	logic wr_one;
	logic rd_high;
	logic gate_new;
	logic [3:0] channel_new;

	assign index = 10'(paddr[ADDR_WIDTH-1:2]);
	assign standby = stop_mode || slow_mode || sleep_mode;
	assign wr_done = psel && penable && pwrite && state_reg.pready;
	assign rd_done = psel && penable && !pwrite && state_reg.pready;
	assign wr_one = wr_done && !standby
		&& (index == `IDX_CONV_CONTROL_ONE);
	assign rd_high = rd_done && (index == `IDX_RESULT_HIGH);

	// ==========================================================
	// Submodules
	conv_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cv(cv.timer)
	);

	sar_register u_sar (
		.pclk(pclk),
		.presetn(presetn),
		.comp_above(comp_above),
		.cv(cv.sar)
	);

	// ==========================================================
	// Conversion time lookup
	always_comb begin
		case (state_reg.ack)
			`ACK_39: total_sel = `CONV_CLOCKS_39;
			`ACK_78: total_sel = `CONV_CLOCKS_78;
			`ACK_156: total_sel = `CONV_CLOCKS_156;
			`ACK_312: total_sel = `CONV_CLOCKS_312;
			`ACK_624: total_sel = `CONV_CLOCKS_624;
			// Reserved codes fall back to the slowest, safest time
			default: total_sel = `CONV_CLOCKS_1248;
		endcase
	end

	assign cv.total = total_sel;
	assign cv.step = 7'(total_sel / `STEP_DIVISOR);

	// ==========================================================
	// Gate and channel as they stand after this edge
	// Routing from these keeps the enables and the gate pin in step
	always_comb begin
		gate_new = state_reg.gate;
		channel_new = state_reg.channel;
		if (standby) begin
			gate_new = `RESET_GATE;
			channel_new = 4'(`RESET_CONTROL_ONE);
		end else if (wr_one) begin
			gate_new = pwdata[`POS_GATE];
			channel_new = pwdata[3:0];
		end
	end

	// ==========================================================
	// Channel routing, one enable per analog input
	for (genvar i = 0; i < `CHANNEL_COUNT; i++) begin : g_route
		// Reserved codes match no input and leave all inputs open
		assign route_sel[i] = !gate_new
			&& (channel_new == 4'(i));
	end

	// ==========================================================
	// Register file and sequencing
	always_comb begin
		logic go;
		logic stop_conv;
		logic active;
		logic [7:0] reset_one;
		go = 1'b0;
		stop_conv = 1'b0;
		active = (state_reg.state != ST_IDLE);
		reset_one = `RESET_CONTROL_ONE;
		state_next = state_reg;
		state_next.irq = 1'b0;
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;

		// Bus answer: one wait cycle, so read data comes from a flop
		if (psel && penable && !state_reg.pready) begin
			state_next.pready = 1'b1;
			state_next.prdata = 32'h0000_0000;
			if (index == `IDX_CONV_CONTROL_ONE) begin
				state_next.prdata[7:0] = {state_reg.start,
					state_reg.mode, state_reg.gate, state_reg.channel};
			end else if (index == `IDX_CONV_CONTROL_TWO) begin
				// Upper two bits have no storage and read as zero
				state_next.prdata[7:0] = {2'h0, state_reg.ladder,
					state_reg.fixed_one, state_reg.ack,
					state_reg.fixed_zero};
			end else if (index == `IDX_RESULT_LOW_AND_STATUS) begin
				// Low nibble is not meaningful and reads as zero here
				state_next.prdata[7:0] = {state_reg.result[1:0],
					state_reg.eoc, active, 4'h0};
			end else if (index == `IDX_RESULT_HIGH) begin
				state_next.prdata[7:0] = state_reg.result[9:2];
			end else begin
				state_next.pslverr = 1'b1;
			end
		end

		// Writes; the standby block keeps the controls at reset
		if (wr_done && !standby) begin
			if (index == `IDX_CONV_CONTROL_ONE) begin
				state_next.start = pwdata[`POS_START];
				state_next.mode = mode_type'(
					pwdata[`POS_MODE_HI:`POS_MODE_LO]);
				state_next.gate = pwdata[`POS_GATE];
				state_next.channel = pwdata[3:0];
			end else if (index == `IDX_CONV_CONTROL_TWO) begin
				state_next.ladder = pwdata[`POS_LADDER];
				state_next.fixed_one = pwdata[`POS_FIXED_ONE];
				state_next.ack = pwdata[`POS_ACK_HI:`POS_ACK_LO];
				state_next.fixed_zero = pwdata[`POS_FIXED_ZERO];
			end
		end

		// End flag clear by the result read; a completion below wins
		if (rd_high) begin
			state_next.eoc = 1'b0;
		end

		case (state_reg.state)
			ST_IDLE: begin
				// A start written while busy waits here until idle
				if (state_reg.start) begin
					state_next.start = 1'b0;
					if (state_reg.mode == MODE_SINGLE
						|| state_reg.mode == MODE_REPEAT) begin
						go = 1'b1;
						state_next.state = ST_SAMPLING;
					end
				end
			end
			ST_SAMPLING: begin
				if (!cv.sampling) begin
					state_next.state = ST_APPROX;
				end
			end
			ST_APPROX: begin
				if (cv.sar_done) begin
					state_next.result = cv.code;
					state_next.eoc = 1'b1;
					state_next.irq = 1'b1;
					if (state_reg.mode == MODE_REPEAT) begin
						go = 1'b1;
						state_next.state = ST_SAMPLING;
					end else begin
						state_next.state = ST_IDLE;
					end
				end
			end
			default: begin
				state_next.state = ST_IDLE;
			end
		endcase

		// Disabling mid-conversion drops the partial result
		if (active && (state_reg.mode == MODE_DISABLED
			|| state_reg.mode == MODE_RESERVED)) begin
			stop_conv = 1'b1;
		end

		if (stop_conv) begin
			go = 1'b0;
			state_next.state = ST_IDLE;
			state_next.result = state_reg.result;
			state_next.eoc = state_reg.eoc && state_next.eoc;
			state_next.irq = 1'b0;
		end

		// Standby: abort, reinitialise controls, lose the result
		if (standby) begin
			go = 1'b0;
			stop_conv = active;
			state_next.state = ST_IDLE;
			state_next.irq = 1'b0;
			state_next.start = reset_one[`POS_START];
			state_next.mode = mode_type'(
				reset_one[`POS_MODE_HI:`POS_MODE_LO]);
			state_next.gate = reset_one[`POS_GATE];
			state_next.channel = reset_one[3:0];
			{state_next.ladder, state_next.fixed_one,
				state_next.ack, state_next.fixed_zero} =
				6'(`RESET_CONTROL_TWO);
			state_next.result = `RESET_RESULT;
			state_next.eoc = 1'b0;
		end

		cv.start = go;
		cv.abort = stop_conv;

		// Analog controls, registered so every pin comes from a flop
		state_next.route = route_sel;
		state_next.sample_hold = (state_next.state == ST_SAMPLING);
		// New ladder bit, so standby drops the ladder on its first edge
		state_next.ladder_out = state_next.ladder
			|| (state_next.state != ST_IDLE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.state <= ST_IDLE;
			state_reg.gate <= `RESET_GATE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign dac_code = cv.code;
	assign sample_hold = state_reg.sample_hold;
	assign ladder_connect = state_reg.ladder_out;
	assign analog_input_gate = state_reg.gate;
	assign channel_enable = state_reg.route;
	assign conversion_done_irq = state_reg.irq;

endmodule

// ===== logic/sar_register.sv
// Successive approximation register with comparator synchroniser
module sar_register
	import sar_adc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Analog comparator, high when input is above the trial level
	input wire logic comp_above,
	// Sequencing
	conv_if.sar cv
);

	sar_regs_type state_reg;
	sar_regs_type state_next;

	assign cv.code = state_reg.code;
	assign cv.sar_done = state_reg.done;

	always_comb begin
		state_next = state_reg;
		state_next.sync_first = comp_above;
		state_next.sync_second = state_reg.sync_first;
		state_next.done = 1'b0;
		if (cv.start) begin
			state_next.code = 10'h200;
			state_next.mask = 10'h200;
		end else if (cv.abort) begin
			state_next.mask = 10'h000;
		end else if (cv.step_end && (state_reg.mask != 10'h000)) begin
			// Keep the trial bit when the input sits above the ladder
			if (!state_reg.sync_second) begin
				state_next.code = state_reg.code & ~state_reg.mask;
			end
			state_next.code = state_next.code | (state_reg.mask >> 1);
			state_next.mask = state_reg.mask >> 1;
			state_next.done = (state_reg.mask == 10'h001);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule

// ===== pkg/conv_if.sv
// Signals between the control, the cycle timer and the approximation register
interface conv_if;
	logic start;
	logic abort;
	logic [10:0] total;
	logic [6:0] step;
	logic sampling;
	logic step_end;
	logic sar_done;
	logic [9:0] code;

	modport ctrl (output start, abort, total, step,
		input sampling, sar_done, code);
	modport timer (input start, abort, total, step,
		output sampling, step_end);
	modport sar (input start, abort, step_end,
		output sar_done, code);
endinterface

// ===== pkg/sar_adc_defs.svh
// Register map, field positions, reset values and conversion timing
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_CONV_CONTROL_ONE 10'h00e
`define IDX_CONV_CONTROL_TWO 10'h00f
`define IDX_RESULT_LOW_AND_STATUS 10'h020
`define IDX_RESULT_HIGH 10'h021

// ==========================================================
// Field positions
`define POS_START 7
`define POS_MODE_HI 6
`define POS_MODE_LO 5
`define POS_GATE 4
`define POS_LADDER 5
`define POS_FIXED_ONE 4
`define POS_ACK_HI 3
`define POS_ACK_LO 1
`define POS_FIXED_ZERO 0
`define POS_EOC 5
`define POS_BUSY 4

// ==========================================================
// Reset values
`define RESET_CONTROL_ONE 8'h10
`define RESET_CONTROL_TWO 8'h00
`define RESET_GATE 1'b1
`define RESET_RESULT 10'h000

// ==========================================================
// Conversion time codes and oscillator clock counts
`define ACK_39 3'h0
`define ACK_78 3'h2
`define ACK_156 3'h3
`define ACK_312 3'h4
`define ACK_624 3'h5
`define ACK_1248 3'h6
`define CONV_CLOCKS_39 11'h027
`define CONV_CLOCKS_78 11'h04e
`define CONV_CLOCKS_156 11'h09c
`define CONV_CLOCKS_312 11'h138
`define CONV_CLOCKS_624 11'h270
`define CONV_CLOCKS_1248 11'h4e0
// Bit-decision step: one thirteenth of the conversion time
`define STEP_DIVISOR 11'h00d
`define CHANNEL_COUNT 6

`endif

// ===== pkg/sar_adc_pkg.sv
// Types shared by the converter control modules
package sar_adc_pkg;

	typedef enum logic [1:0] {
		MODE_DISABLED = 2'h0,
		MODE_SINGLE = 2'h1,
		MODE_RESERVED = 2'h2,
		MODE_REPEAT = 2'h3
	} mode_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SAMPLING = 3'h2,
		ST_APPROX = 3'h4
	} ctrl_state_type;

	typedef struct packed {
		ctrl_state_type state;
		logic start;
		mode_type mode;
		logic gate;
		logic [3:0] channel;
		logic ladder;
		logic fixed_one;
		logic [2:0] ack;
		logic fixed_zero;
		logic [9:0] result;
		logic eoc;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [5:0] route;
		logic sample_hold;
		logic ladder_out;
	} ctrl_regs_type;

	typedef struct packed {
		logic run;
		logic [10:0] rem;
		logic [6:0] scnt;
	} timer_regs_type;

	typedef struct packed {
		logic sync_first;
		logic sync_second;
		logic [9:0] code;
		logic [9:0] mask;
		logic done;
	} sar_regs_type;

endpackage

// ===== testbench/sar_adc_control_props.sv
// Concurrent checks on the converter control ports
module sar_adc_control_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Standby requests
	input wire logic stop_mode,
	input wire logic slow_mode,
	input wire logic sleep_mode,
	// Analog side and completion
	input wire logic sample_hold,
	input wire logic ladder_connect,
	input wire logic analog_input_gate,
	input wire logic [5:0] channel_enable,
	input wire logic conversion_done_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Sequences
	sequence s_first_access;
		psel && penable && $rose(penable);
	endsequence
	// Two samples so the registered clear has landed
	sequence s_standby_held;
		(stop_mode || slow_mode || sleep_mode) [*2];
	endsequence
	// ==========================================================
	// Properties
	a_one_wait: assert property (s_first_access |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_irq_pulse: assert property (conversion_done_irq |=> !conversion_done_irq)
		else $error("done event longer than one cycle");
	a_route_onehot: assert property ($onehot0(channel_enable))
		else $error("more than one input routed");
	a_gate_blocks: assert property (analog_input_gate |-> channel_enable == 6'h00)
		else $error("input routed while gated off");
	a_ladder_sample: assert property (sample_hold |-> ladder_connect)
		else $error("ladder off while sampling");
	a_standby_quiet: assert property (s_standby_held |->
		!conversion_done_irq && !sample_hold)
		else $error("conversion alive in standby");
	a_standby_reset: assert property (s_standby_held |->
		!ladder_connect && analog_input_gate)
		else $error("controls not reset in standby");
endmodule

bind sar_adc_control sar_adc_control_props i_props (.pclk, .presetn, .psel,
	.penable, .prdata, .pready, .pslverr, .stop_mode, .slow_mode, .sleep_mode,
	.sample_hold, .ladder_connect, .analog_input_gate, .channel_enable,
	.conversion_done_irq);

// ===== testbench/test_sar_adc_control.sv
// Self-checking bench for the converter control block
module test_sar_adc_control;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Byte addresses and tables
	localparam logic [11:0] CR1 = 12'h038;
	localparam logic [11:0] CR2 = 12'h03c;
	localparam logic [11:0] DRL = 12'h080;
	localparam logic [11:0] DRH = 12'h084;
	localparam logic [2:0] CODES [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5,
		3'h6, 3'h1};
	localparam logic [7:0] OFF_MODES [2] = '{8'h82, 8'hc7};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic stop_mode = 1'b0;
	logic slow_mode = 1'b0;
	logic sleep_mode = 1'b0;
	logic [9:0] vin = 10'h000;
	logic comp_above;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr, sample_hold, ladder_connect;
	logic analog_input_gate, conversion_done_irq;
	logic [9:0] dac_code;
	logic [5:0] channel_enable;
	logic [31:0] seed = 32'h37be_be46;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	// Ideal comparator: input level sits half a step above vin
	assign comp_above = ({vin, 1'b1} > {dac_code, 1'b0});
	sar_adc_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .stop_mode, .slow_mode,
		.sleep_mode, .comp_above, .dac_code, .sample_hold, .ladder_connect,
		.analog_input_gate, .channel_enable, .conversion_done_irq);
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			results();
		end
	end
	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int clocks(input logic [2:0] c);
		case (c)
			3'h0: return 39;
			3'h2: return 78;
			3'h3: return 156;
			3'h4: return 312;
			3'h5: return 624;
			default: return 1248;
		endcase
	endfunction
	function automatic logic [7:0] lo_exp(input logic [9:0] r, input logic e,
		input logic b);
		return {r[1:0], e, b, 4'h0};
	endfunction
	function automatic logic [5:0] route(input logic [7:0] d);
		return (!d[4] && d[3:0] < 4'h6) ? 6'h01 << d[3:0] : 6'h00;
	endfunction
	task automatic results();
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; returns one edge after completion
	// so a following call never drives the bus in the same time step
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(32'(pready), 32'h0000_0001);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] m,
		input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rdat & {24'h00_0000, m}, {24'h00_0000, e});
	endtask
	task automatic wait_irq(output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (conversion_done_irq !== 1'b1 && n < 3000);
	endtask
	task automatic quiet(input int c);
		repeat (c) begin
			@(posedge pclk);
			chk(32'(conversion_done_irq), 32'h0000_0000);
		end
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		int n;
		logic [3:0] ch;
		logic [9:0] old;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CR1, 8'hff, 8'h10);
		rd(CR2, 8'h3f, 8'h00);
		rd(DRH, 8'hff, 8'h00);
		rd(DRL, 8'hf0, 8'h00);
		apb(1'b0, 12'h040, 8'h00);
		chk(rdat, 32'h0000_0000);
		chk(32'(rerr), 32'h0000_0001);
		apb(1'b1, DRH, 8'h5a);
		rd(DRH, 8'hff, 8'h00);
		foreach (OFF_MODES[i]) begin
			apb(1'b1, CR1, OFF_MODES[i]);
			quiet(60);
			chk(32'(channel_enable), 32'(route(OFF_MODES[i])));
			rd(CR1, 8'hff, OFF_MODES[i] & 8'h7f);
		end
		foreach (CODES[i]) begin
			vin <= 10'(rnd());
			ch = 4'(rnd() % 6);
			apb(1'b1, CR2, {4'h1, CODES[i], 1'b0});
			apb(1'b1, CR1, {4'h2, ch});
			repeat (2) @(posedge pclk);
			chk(32'(channel_enable), 32'(route({4'h2, ch})));
			chk(32'(analog_input_gate), 32'h0000_0000);
			apb(1'b1, CR1, {4'ha, ch});
			wait_irq(n);
			chk(n, clocks(CODES[i]) + 1);
			rd(CR1, 8'hff, {4'h2, ch});
			rd(DRL, 8'hf0, lo_exp(vin, 1'b1, 1'b0));
			rd(DRH, 8'hff, vin[9:2]);
			rd(DRL, 8'hf0, lo_exp(vin, 1'b0, 1'b0));
			chk(32'(ladder_connect), 32'h0000_0000);
		end
		vin <= 10'(rnd());
		apb(1'b1, CR2, 8'h10);
		apb(1'b1, CR1, 8'he1);
		wait_irq(n);
		wait_irq(n);
		chk(n, 39);
		rd(DRL, 8'hf0, lo_exp(vin, 1'b1, 1'b1));
		old = vin;
		vin <= ~vin;
		apb(1'b1, CR1, 8'h01);
		quiet(80);
		rd(DRL, 8'hf0, lo_exp(old, 1'b1, 1'b0));
		rd(DRH, 8'hff, old[9:2]);
		// Each standby request in turn, in mid-conversion
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, CR2, 8'h3c);
			apb(1'b1, CR1, 8'ha3);
			chk(32'(ladder_connect), 32'h0000_0001);
			repeat (20) @(posedge pclk);
			{stop_mode, slow_mode, sleep_mode} <= 3'h4 >> k;
			repeat (2) @(posedge pclk);
			apb(1'b1, CR1, 8'ha3);
			rd(CR1, 8'hff, 8'h10);
			rd(CR2, 8'h3f, 8'h00);
			rd(DRL, 8'hf0, 8'h00);
			{stop_mode, slow_mode, sleep_mode} <= 3'h0;
			quiet(100);
			chk(32'(ladder_connect), 32'h0000_0000);
		end
		results();
	end
endmodule
